/* rtl/rpc_codec.sv */
// Uplink payload builder, downlink period parser and network join sequencer
//
// Summary of operation
// - Uplink payload holds at most 11 bytes and at most 7 quantities.
// - Every payload value is an unsigned integer code.
// - Byte 0 is a presence mask; set bit means that field follows.
// - Mask bits: 0 temp+humidity, 1 pressure, 2 air quality, 3 light, 4 CO2.
// - Field order fixed; two-byte fields go low byte first.
// - Temperature code is (degrees plus 100) times 100.
// - Humidity code is percent times 2.5 in one byte.
// - Pressure code is (hPa minus 800) times 100.
// - Air-quality index sits in the low nine bits of its word.
// - Two-bit accuracy sits at bits 9 and 10 of the air-quality word.
// - Light code is logarithmic; lux equals exp(code/20) minus one.
// - CO2 field carries ppm directly, unscaled.
// - Only downlink type 1 exists; it sets the uplink period.
// - Downlink byte 0 is the type, byte 1 the period in minutes.
// - Join at every power-up unless personalised activation is selected; retry after a random delay near 3 minutes.
// - Both over-the-air and personalised activation, chosen by configuration.
// - A factory-set unique device identifier is readable in the settings.
`timescale 1ns/10ps
`default_nettype none
`include "rpc_consts.svh"

module rpc_codec #(
  parameter logic [31:0] MINUTE_CYCLES = `RPC_MINUTE_S * `RPC_CLK_HZ,
  parameter logic [31:0] RETRY_CYCLES  = `RPC_RETRY_S * `RPC_CLK_HZ,
  parameter logic [31:0] JITTER_MASK   = `RPC_JITTER_MASK,
  // Arbitrary identifier value, replaced per unit at manufacture
  parameter logic [63:0] DEV_ID        = `RPC_DEV_ID
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        th_valid_in,
  input  wire logic [15:0] temp_in,
  input  wire logic [9:0]  rh_in,
  input  wire logic        press_valid_in,
  input  wire logic [16:0] press_in,
  input  wire logic        aq_valid_in,
  input  wire logic [8:0]  aq_index_in,
  input  wire logic [1:0]  aq_acc_in,
  input  wire logic        light_valid_in,
  input  wire logic [7:0]  light_code_in,
  input  wire logic        co2_valid_in,
  input  wire logic [15:0] co2_in,
  output logic [7:0]       tx_data_out,
  output logic             tx_last_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  input  wire logic [7:0]  dl_data_in,
  input  wire logic        dl_valid_in,
  input  wire logic        dl_last_in,
  output logic             join_req_out,
  input  wire logic        join_ok_in,
  input  wire logic        join_fail_in,
  output logic             joined_out
);

  rpc_pkg::rpc_state_t st;
  rpc_pkg::rpc_state_t next_st;
  logic                go;
  logic                push;
  logic                fifo_ready;
  logic [7:0]          cur_byte;
  logic                cur_last;
  logic [8:0]          fifo_out;

  function automatic logic period_ok(input logic [7:0] v);
    period_ok = (v >= `RPC_PERIOD_MIN) && (v <= `RPC_PERIOD_MAX);
  endfunction : period_ok

  // Whether payload byte idx is present for the given mask
  function automatic logic incl(input logic [3:0] idx, input logic [7:0] m);
    unique case (idx)
      4'h0:             incl = 1'b1;
      4'h1, 4'h2, 4'h3: incl = m[`RPC_BIT_TH];
      4'h4, 4'h5:       incl = m[`RPC_BIT_PRESS];
      4'h6, 4'h7:       incl = m[`RPC_BIT_AQ];
      4'h8:             incl = m[`RPC_BIT_LIGHT];
      4'h9, 4'hA:       incl = m[`RPC_BIT_CO2];
      default:          incl = 1'b0;
    endcase
  endfunction : incl

  function automatic logic [3:0] last_idx(input logic [7:0] m);
    last_idx = 4'h0;
    for (int i = 1; i <= 10; i++) begin
      if (incl(4'(i), m)) begin
        last_idx = 4'(i);
      end
    end
  endfunction : last_idx

  // Layout of the eleven possible bytes, low byte first
  function automatic logic [7:0] byte_of(input rpc_pkg::rpc_state_t s);
    unique case (s.idx)
      4'h0:    byte_of = s.mask;
      4'h1:    byte_of = s.t[7:0];
      4'h2:    byte_of = s.t[15:8];
      4'h3:    byte_of = s.h;
      4'h4:    byte_of = s.p[7:0];
      4'h5:    byte_of = s.p[15:8];
      4'h6:    byte_of = s.aq[7:0];
      4'h7:    byte_of = s.aq[15:8];
      4'h8:    byte_of = s.l;
      4'h9:    byte_of = s.co2[7:0];
      4'hA:    byte_of = s.co2[15:8];
      default: byte_of = 8'h00;
    endcase
  endfunction : byte_of

  assign cur_byte     = byte_of(st);
  assign cur_last     = (st.idx == last_idx(st.mask));
  assign push         = (st.tst == rpc_pkg::RPC_T_SEND) && incl(st.idx, st.mask);
  assign go           = (st.tst == rpc_pkg::RPC_T_IDLE) && (st.jst == rpc_pkg::RPC_J_UP)
                        && ((st.minutes >= st.period) || st.send_req);
  assign rdata_out    = st.rdata;
  assign join_req_out = st.join_req;
  assign joined_out   = (st.jst == rpc_pkg::RPC_J_UP);
  assign tx_data_out  = fifo_out[7:0];
  assign tx_last_out  = fifo_out[8];

  always_comb begin
    next_st          = st;
    next_st.join_req = 1'b0;
    next_st.rdata    = 32'h0000_0000;
    next_st.lfsr     = {st.lfsr[30:0], st.lfsr[31] ^ st.lfsr[21] ^ st.lfsr[1] ^ st.lfsr[0]};

    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        `RPC_ADDR_CTRL: begin
          next_st.abp      = wdata_in[`RPC_CTRL_ABP];
          next_st.send_req = wdata_in[`RPC_CTRL_SEND];
        end
        `RPC_ADDR_ENABLE: next_st.en_mask = wdata_in[4:0];
        `RPC_ADDR_PERIOD: begin
          if (period_ok(wdata_in[7:0])) begin
            next_st.period = wdata_in[7:0];
          end
        end
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle only
    if (rd_in) begin
      unique case (addr_in)
        `RPC_ADDR_CTRL:     next_st.rdata = {30'h0000_0000, st.send_req, st.abp};
        `RPC_ADDR_ENABLE:   next_st.rdata = {27'h000_0000, st.en_mask};
        `RPC_ADDR_PERIOD:   next_st.rdata = {24'h00_0000, st.period};
        `RPC_ADDR_STATUS:   next_st.rdata = {16'h0000, st.retries, 3'h0,
                                             st.tst, joined_out, st.jst};
        `RPC_ADDR_DEVID_LO: next_st.rdata = DEV_ID[31:0];
        `RPC_ADDR_DEVID_HI: next_st.rdata = DEV_ID[63:32];
        default:            next_st.rdata = 32'h0000_0000;
      endcase
    end

    // Join sequencer; only reset or an undefined state code brings it back to the request state
    unique case (st.jst)
      rpc_pkg::RPC_J_REQ: begin
        // A select written in the first cycle after reset already counts here
        if (next_st.abp) begin
          next_st.jst = rpc_pkg::RPC_J_UP;
        end else begin
          next_st.join_req = 1'b1;
          next_st.jst      = rpc_pkg::RPC_J_WAIT;
        end
      end
      rpc_pkg::RPC_J_WAIT: begin
        if (join_ok_in) begin
          next_st.jst = rpc_pkg::RPC_J_UP;
        end else if (join_fail_in) begin
          // Random shortening spreads retries of many units apart
          next_st.backoff = RETRY_CYCLES - (st.lfsr & JITTER_MASK);
          next_st.retries = st.retries + 8'h01;
          next_st.jst     = rpc_pkg::RPC_J_BACKOFF;
        end
      end
      rpc_pkg::RPC_J_BACKOFF: begin
        if (st.backoff == 32'h0000_0000) begin
          next_st.join_req = 1'b1;
          next_st.jst      = rpc_pkg::RPC_J_WAIT;
        end else begin
          next_st.backoff = st.backoff - 32'h0000_0001;
        end
      end
      rpc_pkg::RPC_J_UP: ;
      default: next_st.jst = rpc_pkg::RPC_J_REQ;
    endcase

    // Period timer in whole minutes
    if (st.tick >= MINUTE_CYCLES - 32'h0000_0001) begin
      next_st.tick = 32'h0000_0000;
      if (st.minutes != 8'hFF) begin
        next_st.minutes = st.minutes + 8'h01;
      end
    end else begin
      next_st.tick = st.tick + 32'h0000_0001;
    end

    // Snapshot of readings as unsigned codes
    if (go) begin
      next_st.tst      = rpc_pkg::RPC_T_SEND;
      next_st.idx      = 4'h0;
      // A send-now written in this very cycle survives for the next payload
      next_st.send_req = wr_in && (addr_in == `RPC_ADDR_CTRL) && wdata_in[`RPC_CTRL_SEND];
      next_st.minutes  = 8'h00;
      next_st.tick     = 32'h0000_0000;
      next_st.mask     = {3'b000,
                          co2_valid_in && st.en_mask[`RPC_BIT_CO2],
                          light_valid_in && st.en_mask[`RPC_BIT_LIGHT],
                          aq_valid_in && st.en_mask[`RPC_BIT_AQ],
                          press_valid_in && st.en_mask[`RPC_BIT_PRESS],
                          th_valid_in && st.en_mask[`RPC_BIT_TH]};
      next_st.t        = temp_in + `RPC_T_OFFSET;
      next_st.h        = rh_in[9:2];
      next_st.p        = 16'(press_in - `RPC_P_OFFSET);
      next_st.aq       = {5'b00000, aq_acc_in, aq_index_in};
      next_st.l        = light_code_in;
      next_st.co2      = co2_in;
    end

    // Byte walk: absent bytes are skipped, present ones wait for FIFO room
    if (st.tst == rpc_pkg::RPC_T_SEND) begin
      if (!push || fifo_ready) begin
        if (st.idx >= `RPC_IDX_LAST || (push && cur_last)) begin
          next_st.tst = rpc_pkg::RPC_T_IDLE;
        end else begin
          next_st.idx = st.idx + 4'h1;
        end
      end
    end

    // Downlink parse: exactly two bytes, type 1, period in range
    if (dl_valid_in) begin
      if (st.dl_cnt == 2'h0) begin
        next_st.dl_type = dl_data_in;
      end
      if (st.dl_cnt == 2'h1 && dl_last_in && st.dl_type == `RPC_DL_TYPE_PER
          && period_ok(dl_data_in)) begin
        next_st.period = dl_data_in;
      end
      if (dl_last_in) begin
        next_st.dl_cnt = 2'h0;
      end else if (st.dl_cnt != 2'h3) begin
        next_st.dl_cnt = st.dl_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st         <= '0;
      st.jst     <= rpc_pkg::RPC_J_REQ;
      st.tst     <= rpc_pkg::RPC_T_IDLE;
      st.en_mask <= `RPC_EN_RST;
      st.period  <= `RPC_PERIOD_RST;
      st.lfsr    <= `RPC_LFSR_SEED;
    end else begin
      st <= next_st;
    end
  end

  // Four bytes of slack let the walk run ahead of a slow radio
  rpc_fifo #(
    .WIDTH(9),
    .DEPTH(4)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({cur_last, cur_byte}),
    .out_valid_out (tx_valid_out),
    .out_ready_in  (tx_ready_in),
    .out_data_out  (fifo_out)
  );

  a_payload_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    push |-> st.idx <= `RPC_IDX_LAST)
    else $error("payload index beyond last field");

  a_mask_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
    go |=> st.mask[7:5] == 3'b000
           && st.mask[4] == $past(co2_valid_in && st.en_mask[4])
           && st.mask[0] == $past(th_valid_in && st.en_mask[0]))
    else $error("presence mask wrong");

  a_mask_first: assert property (@(posedge clk_in) disable iff (rst_in)
    go |=> push && cur_byte == st.mask)
    else $error("payload does not open with the mask");

  a_temp_code: assert property (@(posedge clk_in) disable iff (rst_in)
    go |=> st.t == 16'($past(temp_in) + 16'h2710))
    else $error("temperature code wrong");

  a_hum_press: assert property (@(posedge clk_in) disable iff (rst_in)
    go |=> st.h == $past(rh_in[9:2]) && st.p == 16'($past(press_in) - 17'h1_3880))
    else $error("humidity or pressure code wrong");

  a_aq_word: assert property (@(posedge clk_in) disable iff (rst_in)
    go |=> (st.aq & 16'h01FF) == 16'($past(aq_index_in))
           && ((st.aq >> 9) & 16'h0003) == 16'($past(aq_acc_in)))
    else $error("air quality word wrong");

  a_low_first: assert property (@(posedge clk_in) disable iff (rst_in)
    push && fifo_ready && st.idx == 4'h1 |=> push && cur_byte == st.t[15:8])
    else $error("temperature high byte not next");

  a_co2_direct: assert property (@(posedge clk_in) disable iff (rst_in)
    go |=> st.co2 == $past(co2_in) && st.l == $past(light_code_in))
    else $error("carbon dioxide or light field altered");

  a_period_set: assert property (@(posedge clk_in) disable iff (rst_in)
    dl_valid_in && dl_last_in && st.dl_cnt == 2'h1 && !wr_in
    |=> st.period == (($past(st.dl_type) == 8'h01 && $past(dl_data_in) >= 8'h01
                       && $past(dl_data_in) <= 8'hB4) ? $past(dl_data_in)
                                                      : $past(st.period)))
    else $error("downlink period handling wrong");

  a_join_retry: assert property (@(posedge clk_in) disable iff (rst_in)
    st.jst == rpc_pkg::RPC_J_WAIT && !join_ok_in && join_fail_in
    |=> st.jst == rpc_pkg::RPC_J_BACKOFF ##1 !join_req_out)
    else $error("failed join not followed by back-off");

  a_abp_direct: assert property (@(posedge clk_in) disable iff (rst_in)
    st.jst == rpc_pkg::RPC_J_REQ && wr_in && addr_in == `RPC_ADDR_CTRL
    && wdata_in[`RPC_CTRL_ABP] |=> joined_out && !join_req_out)
    else $error("personalised activation still requested a join");

endmodule : rpc_codec

`default_nettype wire

/* rtl/rpc_consts.svh */
// Register offsets, field positions, reset values and timing constants of the payload codec
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

`define RPC_ADDR_CTRL     8'h00
`define RPC_ADDR_ENABLE   8'h04
`define RPC_ADDR_PERIOD   8'h08
`define RPC_ADDR_STATUS   8'h0C
`define RPC_ADDR_DEVID_LO 8'h10
`define RPC_ADDR_DEVID_HI 8'h14

`define RPC_CTRL_ABP      0
`define RPC_CTRL_SEND     1
`define RPC_EN_RST        5'h1F
`define RPC_PERIOD_RST    8'h0A
`define RPC_PERIOD_MIN    8'h01
`define RPC_PERIOD_MAX    8'hB4

`define RPC_BIT_TH        0
`define RPC_BIT_PRESS     1
`define RPC_BIT_AQ        2
`define RPC_BIT_LIGHT     3
`define RPC_BIT_CO2       4

`define RPC_IDX_LAST      4'hA
`define RPC_DL_TYPE_PER   8'h01
`define RPC_T_OFFSET      16'h2710
`define RPC_P_OFFSET      17'h1_3880

`define RPC_CLK_HZ        32'h0098_9680
`define RPC_MINUTE_S      32'h0000_003C
`define RPC_RETRY_S       32'h0000_00B4
`define RPC_JITTER_MASK   32'h03FF_FFFF
`define RPC_LFSR_SEED     32'hACE1_0001
`define RPC_DEV_ID        64'h0123_4567_89AB_CDEF

`endif

/* rtl/rpc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module rpc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } rpc_fifo_st_t;

  rpc_fifo_st_t st;
  rpc_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign in_ready_out  = (st.cnt != CW'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out  = st.mem[st.rd];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data_in;
      next_st.wr         = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    // Simultaneous push and pop keeps the count
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : rpc_fifo

`default_nettype wire

/* rtl/rpc_pkg.sv */
// Types shared by the payload codec
`default_nettype none
package rpc_pkg;

  typedef enum logic [2:0] {
    RPC_J_REQ     = 3'b000,
    RPC_J_WAIT    = 3'b001,
    RPC_J_UP      = 3'b011,
    RPC_J_BACKOFF = 3'b010
  } rpc_join_t;

  typedef enum logic {
    RPC_T_IDLE = 1'b0,
    RPC_T_SEND = 1'b1
  } rpc_tx_t;

  typedef struct packed {
    rpc_join_t   jst;
    rpc_tx_t     tst;
    logic        abp;
    logic        send_req;
    logic [4:0]  en_mask;
    logic [7:0]  period;
    logic [31:0] tick;
    logic [7:0]  minutes;
    logic [31:0] backoff;
    logic [31:0] lfsr;
    logic [7:0]  retries;
    logic        join_req;
    logic [3:0]  idx;
    logic [7:0]  mask;
    logic [15:0] t;
    logic [7:0]  h;
    logic [15:0] p;
    logic [15:0] aq;
    logic [7:0]  l;
    logic [15:0] co2;
    logic [1:0]  dl_cnt;
    logic [7:0]  dl_type;
    logic [31:0] rdata;
  } rpc_state_t;

endpackage : rpc_pkg

`default_nettype wire

/* sim/rpc_net_model.sv */
// Network side model: uplink byte sink, downlink sender and join responder
`timescale 1ns/10ps
`default_nettype none

module rpc_net_model #(
  parameter int FAILS = 1
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_last_in,
  input  wire logic       tx_valid_in,
  output var  logic       tx_ready_out,
  output var  logic [7:0] dl_data_out,
  output var  logic       dl_valid_out,
  output var  logic       dl_last_out,
  input  wire logic       join_req_in,
  output var  logic       join_ok_out,
  output var  logic       join_fail_out
);
  logic [8:0] rxq[$];
  int         npl = 0;
  int         nreq = 0;
  int         gap = 0;
  int         cyc = 0;
  int         tfail = 0;
  int         left = FAILS;

  initial begin
    tx_ready_out  = 1'b1;
    dl_data_out   = 8'h5A;
    dl_valid_out  = 1'b0;
    dl_last_out   = 1'b0;
    join_ok_out   = 1'b0;
    join_fail_out = 1'b0;
  end

  // Slow mode takes a byte only every other cycle so the FIFO backs up
  always @(posedge clk_in) begin
    cyc <= rst_in ? 0 : cyc + 1;
    tx_ready_out <= !slow_in || !tx_ready_out;
    if (tx_valid_in && tx_ready_out) begin
      rxq.push_back({tx_last_in, tx_data_in});
      if (tx_last_in)
        npl <= npl + 1;
    end
  end

  // The first FAILS join requests are refused, later ones accepted
  always @(posedge clk_in) begin
    if (join_req_in) begin
      nreq = nreq + 1;
      gap = cyc - tfail;
      repeat (3) @(posedge clk_in);
      if (left > 0) begin
        join_fail_out <= 1'b1;
        left = left - 1;
        tfail = cyc;
      end else begin
        join_ok_out <= 1'b1;
      end
      @(posedge clk_in);
      join_ok_out   <= 1'b0;
      join_fail_out <= 1'b0;
    end
  end

  // Byte 0 type, byte 1 period; released data shows the inverse of the last byte
  task automatic send_dl(input int n, input logic [23:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      dl_valid_out <= 1'b1;
      dl_data_out  <= v[8*i +: 8];
      dl_last_out  <= (i == n - 1);
    end
    @(posedge clk_in);
    dl_valid_out <= 1'b0;
    dl_last_out  <= 1'b0;
    dl_data_out  <= ~v[8*(n-1) +: 8];
  endtask : send_dl
endmodule : rpc_net_model
`default_nettype wire

/* sim/tb_rpc_codec.sv */
// Self-checking testbench of the payload codec
`timescale 1ns/10ps
`default_nettype none
`include "rpc_consts.svh"

module tb_rpc_codec;
  localparam logic [31:0] RETRY = 32'h0000_03E8;
  // Arbitrary identifier value
  localparam logic [63:0] ID    = 64'h0F0E_0D0C_0B0A_0908;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic        th_valid_in = 1'b1;
  logic [15:0] temp_in = 16'h0883;
  logic [9:0]  rh_in = 10'h21C;
  logic        press_valid_in = 1'b1;
  logic [16:0] press_in = 17'h1_7E90;
  logic        aq_valid_in = 1'b1;
  logic [8:0]  aq_index_in = 9'h0B1;
  logic [1:0]  aq_acc_in = 2'h2;
  logic        light_valid_in = 1'b1;
  logic [7:0]  light_code_in = 8'h65;
  logic        co2_valid_in = 1'b1;
  logic [15:0] co2_in = 16'h01C8;
  logic [7:0]  tx_data_out;
  logic        tx_last_out;
  logic        tx_valid_out;
  logic        tx_ready_in;
  logic [7:0]  dl_data_in;
  logic        dl_valid_in;
  logic        dl_last_in;
  logic        join_req_out;
  logic        join_ok_in;
  logic        join_fail_in;
  logic        joined_out;
  logic        slow = 1'b0;
  logic [8:0]  expq[$];
  int          error_cnt = 0;
  int          total_checks = 0;

  always #50 clk_in = ~clk_in;

  // Short minute and retry times keep the run brief
  rpc_codec #(.MINUTE_CYCLES(32'h0000_0014), .RETRY_CYCLES(RETRY),
    .JITTER_MASK(32'h0000_00FF), .DEV_ID(ID)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .th_valid_in(th_valid_in),
    .temp_in(temp_in), .rh_in(rh_in), .press_valid_in(press_valid_in),
    .press_in(press_in), .aq_valid_in(aq_valid_in), .aq_index_in(aq_index_in),
    .aq_acc_in(aq_acc_in), .light_valid_in(light_valid_in),
    .light_code_in(light_code_in), .co2_valid_in(co2_valid_in), .co2_in(co2_in),
    .tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .dl_data_in(dl_data_in), .dl_valid_in(dl_valid_in), .dl_last_in(dl_last_in),
    .join_req_out(join_req_out), .join_ok_in(join_ok_in),
    .join_fail_in(join_fail_in), .joined_out(joined_out));

  rpc_net_model #(.FAILS(1)) NET (
    .clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .tx_data_in(tx_data_out),
    .tx_last_in(tx_last_out), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in),
    .dl_data_out(dl_data_in), .dl_valid_out(dl_valid_in), .dl_last_out(dl_last_in),
    .join_req_in(join_req_out), .join_ok_out(join_ok_in),
    .join_fail_out(join_fail_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask : rdchk

  task automatic put(input logic [7:0] b);
    expq.push_back({1'b0, b});
  endtask : put

  task automatic build(input logic [4:0] m);
    logic [15:0] t;
    logic [16:0] p;
    expq.delete();
    t = temp_in + 16'h2710;
    p = press_in - 17'h1_3880;
    put({3'h0, m});
    if (m[0]) begin
      put(t[7:0]);
      put(t[15:8]);
      put(rh_in[9:2]);
    end
    if (m[1]) begin
      put(p[7:0]);
      put(p[15:8]);
    end
    if (m[2]) begin
      put(aq_index_in[7:0]);
      put({5'h00, aq_acc_in, aq_index_in[8]});
    end
    if (m[3])
      put(light_code_in);
    if (m[4]) begin
      put(co2_in[7:0]);
      put(co2_in[15:8]);
    end
    expq[expq.size()-1][8] = 1'b1;
  endtask : build

  // Trigger one payload by the send-now bit and compare it byte for byte
  task automatic payload(input logic [4:0] m);
    int n0;
    n0 = NET.npl;
    NET.rxq.delete();
    wr(`RPC_ADDR_CTRL, 32'h0000_0002);
    for (int k = 0; k < 200 && NET.npl == n0; k++)
      @(posedge clk_in);
    build(m);
    chk(NET.rxq.size(), expq.size());
    foreach (expq[i])
      chk(NET.rxq[i], expq[i]);
  endtask : payload

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    test_done();
  end

  initial begin
    int          dn[7] = '{2, 2, 2, 2, 3, 1, 2};
    logic [23:0] dv[7] = '{24'h00_0501, 24'h00_0702, 24'h00_0001, 24'h00_B501,
                           24'h06_0601, 24'h00_0001, 24'h00_B401};
    logic [7:0]  dp[7] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'hB4};
    int          n0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(`RPC_ADDR_PERIOD, 32'h0000_000A);
    rdchk(`RPC_ADDR_ENABLE, 32'h0000_001F);
    rdchk(`RPC_ADDR_DEVID_LO, ID[31:0]);
    rdchk(`RPC_ADDR_DEVID_HI, ID[63:32]);
    rdchk(8'h18, 32'h0000_0000);
    wr(`RPC_ADDR_PERIOD, 32'h0000_00B5);
    rdchk(`RPC_ADDR_PERIOD, 32'h0000_000A);
    wr(`RPC_ADDR_PERIOD, 32'h0000_00B4);
    for (int k = 0; k < 3000 && joined_out !== 1'b1; k++)
      @(posedge clk_in);
    chk(joined_out, 1'b1);
    chk(NET.nreq, 2);
    chk(NET.gap >= RETRY - 260 && NET.gap <= RETRY + 8, 1'b1);
    rdchk(`RPC_ADDR_STATUS, 32'h0000_010B);
    slow <= 1'b1;
    payload(5'h1F);
    wr(`RPC_ADDR_ENABLE, 32'h0000_00FF);
    rdchk(`RPC_ADDR_ENABLE, 32'h0000_001F);
    // Boundary codes: cold reading, largest index and accuracy, full CO2 word
    wr(`RPC_ADDR_ENABLE, 32'h0000_001D);
    slow           <= 1'b0;
    light_valid_in <= 1'b0;
    temp_in        <= 16'hF060;
    aq_index_in    <= 9'h1FF;
    aq_acc_in      <= 2'h3;
    co2_in         <= 16'hFFFF;
    payload(5'h15);
    for (int i = 0; i < 7; i++) begin
      NET.send_dl(dn[i], dv[i]);
      rdchk(`RPC_ADDR_PERIOD, {24'h00_0000, dp[i]});
    end
    // A one-minute period must start a payload without the send-now bit
    n0 = NET.npl;
    NET.send_dl(2, 24'h00_0101);
    for (int k = 0; k < 100 && NET.npl == n0; k++)
      @(posedge clk_in);
    chk(NET.npl > n0, 1'b1);
    rst_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    n0 = NET.nreq;
    rst_in   <= 1'b0;
    wr_in    <= 1'b1;
    addr_in  <= `RPC_ADDR_CTRL;
    wdata_in <= 32'h0000_0001;
    @(posedge clk_in);
    wr_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(joined_out, 1'b1);
    chk(NET.nreq, n0);
    test_done();
  end
endmodule : tb_rpc_codec
`default_nettype wire
